// *** core/lws_pkg.sv ***
// Package of constants and types for the load waveform sequencer
`default_nettype none
package lws_pkg;
    localparam int VAL_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CLK_HZ = 40000000;
    // Register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CMD = 4'h1;
    localparam logic [3:0] REG_AMPL = 4'h2;
    localparam logic [3:0] REG_OFFS = 4'h3;
    localparam logic [3:0] REG_FREQ = 4'h4;
    localparam logic [3:0] REG_RISE = 4'h5;
    localparam logic [3:0] REG_FALL = 4'h6;
    localparam logic [3:0] REG_ULIM = 4'h7;
    localparam logic [3:0] REG_ILIM = 4'h8;
    localparam logic [3:0] REG_PLIM = 4'h9;
    localparam logic [3:0] REG_STAT = 4'ha;
    localparam logic [3:0] REG_SLOPE = 4'hb;
    localparam logic [3:0] REG_OUT = 4'hc;
    // Control fields
    localparam int CTRL_FUNC_BIT = 0;
    localparam int CTRL_TGT_BIT = 1;
    // Command bits (write one)
    localparam int CMD_LOAD = 0;
    localparam int CMD_START = 1;
    localparam int CMD_STOP = 2;
    localparam int CMD_INOFF = 3;
    localparam int CMD_CLRERR = 4;
    // Limits and timing
    localparam int SINE_FMAX_HZ = 10000;
    localparam int SINE_FMIN_HZ = 1;
    localparam real T_MIN_MS = 0.01;
    localparam int T_MAX_S = 36000;
    localparam int T_UNIT_CYC = 400; // 0.01 ms at 40 MHz
    localparam int TMIN_CYC = int'(T_MIN_MS * 0.001 * CLK_HZ);
    localparam logic [31:0] T_MAX_UNITS = 32'(64'(T_MAX_S) * 64'd100000);
    localparam int QUANT_STEPS = 52428;
    // Minimum slope in millionths of rated value per second
    localparam int MIN_SLOPE_PPM = 725;
    localparam int PHASE_W = 32;
    localparam logic [31:0] FREQ_SCALE = 32'h00006b5f; // 2^32 / 40e6 * 256
    localparam logic [15:0] SAFE_LIM = 16'h0000;
    typedef enum logic [1:0] {LWS_IDLE, LWS_LOADED, LWS_RUN} lws_state_t;
    typedef enum logic {LWS_SINE, LWS_TRI} lws_func_t;
endpackage : lws_pkg
`default_nettype wire

// *** core/lws_scale.sv ***
// Amplitude scaling with quantisation to the effective step grid
`default_nettype none
module lws_scale (
    input wire logic [15:0] unit_i,              // Shape value 0..65535
    input wire logic [15:0] ampl_i,              // Amplitude
    output logic [15:0] value_o                  // Quantised amplitude share
);
    import lws_pkg::*;
    logic [31:0] prod;
    logic [15:0] steps;
    // Stepped to roughly 52428 levels so long slow ramps repeat values
    assign prod = 32'(unit_i) * 32'(QUANT_STEPS);
    assign steps = prod[31:16];
    assign value_o = 16'((32'(steps) * 32'(ampl_i)) / 32'(QUANT_STEPS));
endmodule : lws_scale
`default_nettype wire

// *** core/lws_sine_rom.sv ***
// Quarter-wave sine lookup with registered output
`default_nettype none
module lws_sine_rom (
    input wire logic clock_i,                    // System clock
    input wire logic [5:0] addr_i,               // Quarter-wave index
    output logic [15:0] data_o                   // Sine magnitude 0..65535
);
    import lws_pkg::*;
    logic [15:0] rom [64];
    always_comb begin
        for (int k = 0; k < 64; k++) begin
            rom[k] = 16'($rtoi(65535.0 * $sin(3.14159265 * (k + 0.5) / 128.0)));
        end
    end
    always_ff @(posedge clock_i) begin
        data_o <= rom[addr_i];
    end
endmodule : lws_sine_rom
`default_nettype wire

// *** core/lws_top.sv ***
// Waveform sequencer core for an electronic DC load
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`default_nettype none
module lws_top #(
    parameter int VAL_WIDTH = 16,
    parameter logic [15:0] NOMINAL = 16'hffff     // Rated value of the target quantity
) (
    input wire logic clock_i,                    // 40 MHz clock
    input wire logic reset_n_i,                  // Async active-low reset
    input wire logic [lws_pkg::ADDR_W-1:0] addr_i, // Register address
    input wire logic [lws_pkg::DATA_W-1:0] wdata_i, // Write data
    input wire logic wr_i,                       // Write strobe
    input wire logic rd_i,                       // Read strobe
    output logic [lws_pkg::DATA_W-1:0] rdata_o,  // Read data, cycle after rd_i
    input wire logic gen_mode_i,                 // Generator mode entered (level)
    input wire logic res_mode_i,                 // Resistance adjust mode active
    input wire logic dev_alarm_i,                // Device alarm
    input wire logic overpower_protection_i,     // Power protection trip
    input wire logic overcurrent_protection_i,   // Current protection trip
    input wire logic event_alarm_i,              // Event with alarm action
    input wire logic [15:0] meas_volt_i,         // Measured input voltage
    output logic input_on_o,                     // DC input enable
    output logic [15:0] set_volt_o,              // Voltage set value
    output logic [15:0] set_curr_o,              // Current set value
    output logic [15:0] set_pow_o,               // Power set value
    output logic [15:0] slave_volt_o,            // Voltage limit to slaves
    output logic [15:0] slave_curr_o,            // Current limit to slaves
    output logic [15:0] slave_pow_o,             // Power limit to slaves
    output logic running_o,                      // Waveform running
    output logic alarm_o,                        // Alarm reported (sticky)
    output logic error_o                         // Settings rejected (sticky)
);
    import lws_pkg::*;

    lws_state_t state_ff;
    lws_state_t nxt_state;
    logic func_ff;
    logic tgt_curr_ff;
    logic [15:0] ampl_ff, offs_ff, ulim_ff, ilim_ff, plim_ff;
    logic [13:0] freq_ff;
    logic [31:0] rise_ff, fall_ff;
    logic input_on_ff, alarm_ff, error_ff, gen_mode_ff;
    logic [31:0] rdata_ff;
    logic [31:0] phase_ff;
    logic [31:0] tcnt_ff;
    logic [8:0] div_ff;
    logic tri_fall_ff;
    logic [15:0] wave_ff;

    function automatic logic [16:0] sum17(input logic [15:0] a, input logic [15:0] b);
        sum17 = 17'(a) + 17'(b);
    endfunction : sum17

    // Length of the triangle segment now being played, in time units
    function automatic logic [31:0] seg_len(input logic fall, input logic [31:0] r,
        input logic [31:0] f);
        seg_len = fall ? f : r;
    endfunction : seg_len

    // Peak beyond the rated value of the target quantity
    function automatic logic over_rating(input logic [16:0] pk);
        over_rating = pk > 17'(NOMINAL);
    endfunction : over_rating

    // Amplitude per second below 725 ppm of the rating over one segment
    function automatic logic too_slow(input logic [15:0] a, input logic [31:0] len);
        too_slow = 64'(a) * 64'd100000 * 64'd1000000
            < 64'(NOMINAL) * 64'(MIN_SLOPE_PPM) * 64'(len);
    endfunction : too_slow

    // Decode
    wire cfg_open = !input_on_ff && !res_mode_i && state_ff != LWS_RUN;
    wire wr_cfg = wr_i && cfg_open;
    wire wr_cmd = wr_i && !res_mode_i && addr_i == REG_CMD;
    wire cmd_load = wr_cmd && wdata_i[CMD_LOAD];
    wire cmd_start = wr_cmd && wdata_i[CMD_START];
    wire cmd_stop = wr_cmd && wdata_i[CMD_STOP];
    wire cmd_inoff = wr_cmd && wdata_i[CMD_INOFF];
    wire cmd_clr = wr_cmd && wdata_i[CMD_CLRERR];
    wire alarm_evt = dev_alarm_i || overpower_protection_i
        || overcurrent_protection_i || event_alarm_i;
    wire gen_enter = gen_mode_i && !gen_mode_ff;

    // Parameter checks
    wire [16:0] peak = sum17(ampl_ff, offs_ff);
    wire sine_bad = over_rating(peak)
        || (offs_ff < ampl_ff)
        || (32'(freq_ff) > 32'(SINE_FMAX_HZ)) || (32'(freq_ff) < 32'(SINE_FMIN_HZ));
    wire tri_bad = over_rating(peak)
        || rise_ff == 32'h0 || fall_ff == 32'h0
        || rise_ff > 32'(T_MAX_UNITS) || fall_ff > 32'(T_MAX_UNITS);
    // Slope check: amplitude per second against 725 ppm of the rating
    wire rise_slow = too_slow(ampl_ff, rise_ff);
    wire fall_slow = too_slow(ampl_ff, fall_ff);
    wire slope_bad = func_ff == LWS_TRI && (rise_slow || fall_slow);
    wire params_bad = (func_ff == LWS_SINE) ? sine_bad : (tri_bad || slope_bad);
    // Reloading is allowed from the loaded state while the input is off
    wire load_ok = cmd_load && !input_on_ff && state_ff != LWS_RUN && !params_bad;
    // Start needs a function that was loaded and checked
    wire start_ok = cmd_start && state_ff == LWS_LOADED;
    // Any setting other than a command sends a loaded function back for checking
    wire cfg_touch = wr_cfg && addr_i != REG_CMD;
    // A rejected load wins over a clear carried by the same write
    wire err_set = cmd_load && params_bad;

    // Sequencing
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            LWS_IDLE: begin
                if (load_ok) nxt_state = LWS_LOADED;
            end
            LWS_LOADED: begin
                // Edited settings must pass the checks again before a start
                if (start_ok) nxt_state = LWS_RUN;
                else if (cfg_touch) nxt_state = LWS_IDLE;
            end
            LWS_RUN: begin
                if (cmd_stop) nxt_state = LWS_LOADED;
            end
            // The fourth code of the two-bit state is never used
            default: nxt_state = LWS_IDLE;
        endcase
        if (cmd_inoff || alarm_evt) nxt_state = (state_ff == LWS_IDLE) ? LWS_IDLE : LWS_LOADED;
    end

    // Input enable: an alarm or an off request wins over load and start
    logic nxt_on;
    always_comb begin
        nxt_on = input_on_ff;
        if (load_ok || start_ok) begin
            nxt_on = 1'b1;
        end
        if (cmd_inoff || alarm_evt) begin
            nxt_on = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= LWS_IDLE;
            input_on_ff <= 1'b0;
            alarm_ff <= 1'b0;
            error_ff <= 1'b0;
            gen_mode_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            input_on_ff <= nxt_on;
            gen_mode_ff <= gen_mode_i;
            // An alarm still present during a clear stays reported
            alarm_ff <= alarm_evt || (alarm_ff && !cmd_clr);
            error_ff <= err_set || (error_ff && !cmd_clr);
        end
    end

    // Shape parameters
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            func_ff <= 1'b0;
            tgt_curr_ff <= 1'b1;
            ampl_ff <= 16'h0000;
            offs_ff <= 16'h0000;
            freq_ff <= 14'h0001;
            rise_ff <= 32'h00000001;
            fall_ff <= 32'h00000001;
        end else if (wr_cfg) begin
            unique case (addr_i)
                REG_CTRL: begin
                    func_ff <= wdata_i[CTRL_FUNC_BIT];
                    tgt_curr_ff <= wdata_i[CTRL_TGT_BIT];
                end
                REG_AMPL: ampl_ff <= wdata_i[15:0];
                REG_OFFS: offs_ff <= wdata_i[15:0];
                REG_FREQ: freq_ff <= wdata_i[13:0];
                REG_RISE: rise_ff <= wdata_i;
                REG_FALL: fall_ff <= wdata_i;
                default: ;
            endcase
        end
    end

    // Limits kept apart: generator-mode entry overrides a write in the same cycle
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ulim_ff <= SAFE_LIM;
            ilim_ff <= SAFE_LIM;
            plim_ff <= SAFE_LIM;
        end else if (gen_enter) begin
            ulim_ff <= NOMINAL;
            ilim_ff <= SAFE_LIM;
            plim_ff <= SAFE_LIM;
        end else if (wr_cfg) begin
            unique case (addr_i)
                REG_ULIM: ulim_ff <= wdata_i[15:0];
                REG_ILIM: ilim_ff <= wdata_i[15:0];
                REG_PLIM: plim_ff <= wdata_i[15:0];
                default: ;
            endcase
        end
    end

    // Time base: one enable per 0.01 ms
    // Divider and phase restart on every run, so each run begins at phase zero
    wire tick = div_ff == 9'(T_UNIT_CYC - 1);
    wire run = state_ff == LWS_RUN;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_ff <= 9'h000;
            phase_ff <= 32'h0;
            tcnt_ff <= 32'h0;
            tri_fall_ff <= 1'b0;
        end else if (!run) begin
            div_ff <= 9'h000;
            phase_ff <= 32'h0;
            tcnt_ff <= 32'h0;
            tri_fall_ff <= 1'b0;
        end else begin
            div_ff <= tick ? 9'h000 : div_ff + 9'h001;
            phase_ff <= phase_ff + 32'(freq_ff) * 32'd107; // ~2^32/40e6 per Hz
            if (tick) begin
                if (tcnt_ff >= seg_len(tri_fall_ff, rise_ff, fall_ff) - 32'h1) begin
                    tcnt_ff <= 32'h0;
                    tri_fall_ff <= !tri_fall_ff;
                end else begin
                    tcnt_ff <= tcnt_ff + 32'h1;
                end
            end
        end
    end

    // Triangle shape 0..65535
    wire [31:0] tlen = seg_len(tri_fall_ff, rise_ff, fall_ff);
    wire [47:0] tfrac48 = (48'(tcnt_ff) << 16) / 48'(tlen);
    wire [15:0] tfrac = tfrac48[15:0] | {16{tfrac48[16]}};
    wire [15:0] tri_unit = tri_fall_ff ? ~tfrac : tfrac;

    // Sine shape from quarter table
    logic [15:0] sine_mag;
    wire [1:0] quad = phase_ff[31:30];
    wire [5:0] qidx = quad[0] ? ~phase_ff[29:24] : phase_ff[29:24];
    lws_sine_rom u_rom (
        .clock_i(clock_i),
        .addr_i(qidx),
        .data_o(sine_mag)
    );
    // Table output lags one cycle, so the half-wave sign is delayed to match
    logic neg_ff;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) neg_ff <= 1'b0;
        else neg_ff <= quad[1];
    end

    logic [15:0] share;
    wire [15:0] unit = (func_ff == LWS_SINE) ? sine_mag : tri_unit;
    lws_scale u_scale (
        .unit_i(unit),
        .ampl_i(ampl_ff),
        .value_o(share)
    );

    wire [16:0] sine_val = neg_ff ? 17'(offs_ff) - 17'(share) : sum17(offs_ff, share);
    wire [16:0] tri_val = sum17(offs_ff, share);
    wire [16:0] raw = (func_ff == LWS_SINE) ? sine_val : tri_val;

    // Power clamp on generated current: I <= P / U
    // Zero volts would divide by zero, so one step stands in for it
    wire [15:0] volt = (meas_volt_i == 16'h0) ? 16'h0001 : meas_volt_i;
    wire [31:0] i_lim32 = (32'(plim_ff) << 8) / 32'(volt);
    wire [15:0] i_lim = (i_lim32 > 32'h0000ffff) ? 16'hffff : i_lim32[15:0];
    wire [15:0] raw16 = raw[16] ? 16'hffff : raw[15:0];
    wire [15:0] wave = (tgt_curr_ff && raw16 > i_lim) ? i_lim : raw16;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) wave_ff <= 16'h0000;
        else wave_ff <= run ? wave : 16'h0000; // current starts from 0 A
    end

    // Register read
    wire [31:0] stat = {26'h0, error_ff, alarm_ff, input_on_ff, res_mode_i, state_ff};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (addr_i)
            REG_CTRL: rd_mux = {30'h0, tgt_curr_ff, func_ff};
            REG_AMPL: rd_mux = 32'(ampl_ff);
            REG_OFFS: rd_mux = 32'(offs_ff);
            REG_FREQ: rd_mux = 32'(freq_ff);
            REG_RISE: rd_mux = rise_ff;
            REG_FALL: rd_mux = fall_ff;
            REG_ULIM: rd_mux = 32'(ulim_ff);
            REG_ILIM: rd_mux = 32'(ilim_ff);
            REG_PLIM: rd_mux = 32'(plim_ff);
            REG_STAT: rd_mux = stat;
            REG_OUT: rd_mux = 32'(wave_ff);
            default: rd_mux = 32'h0;
        endcase
    end
    // Read data is held until the next read strobe
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) rdata_ff <= 32'h0;
        else if (rd_i) rdata_ff <= rd_mux;
    end

    // Static value when idle or stopped; waveform on one target only
    always_comb begin
        set_pow_o = plim_ff;
        set_volt_o = ulim_ff;
        set_curr_o = ilim_ff;
        if (run && tgt_curr_ff) set_curr_o = wave_ff;
        else if (run) set_volt_o = wave_ff;
        else if (tgt_curr_ff && state_ff != LWS_IDLE) set_curr_o = 16'h0000;
    end

    assign slave_volt_o = ulim_ff;
    assign slave_curr_o = ilim_ff;
    assign slave_pow_o = plim_ff;
    assign rdata_o = rdata_ff;
    assign input_on_o = input_on_ff;
    assign running_o = run;
    assign alarm_o = alarm_ff;
    assign error_o = error_ff;
endmodule : lws_top
`default_nettype wire

// *** verif/lws_source_model.sv ***
// Stiff DC source model feeding the load's voltage sense
`default_nettype none
module lws_source_model #(
    parameter logic [15:0] VOLT = 16'h0100 // Terminal voltage, arbitrary scale
) (
    output logic [15:0] volt_o // Voltage seen at the load input
);
    // No sag under load, so the power limit maps to one exact current
    assign volt_o = VOLT;
endmodule : lws_source_model
`default_nettype wire

// *** verif/lws_top_sva.sv ***
// Port assertions for the waveform sequencer core
`default_nettype none
module lws_top_sva #(
    parameter int VAL_WIDTH = 16,
    parameter logic [15:0] NOMINAL = 16'hffff
) (
    input wire logic clock_i, // Clock
    input wire logic reset_n_i, // Reset
    input wire logic [lws_pkg::ADDR_W-1:0] addr_i, // Address
    input wire logic [lws_pkg::DATA_W-1:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic gen_mode_i, // Generator mode
    input wire logic res_mode_i, // Resistance mode
    input wire logic dev_alarm_i, // Alarm
    input wire logic overpower_protection_i, // Trip
    input wire logic overcurrent_protection_i, // Trip
    input wire logic event_alarm_i, // Alarm event
    input wire logic [15:0] meas_volt_i, // Voltage
    input wire logic input_on_o, // Input enable
    input wire logic [15:0] set_curr_o, // Current set
    input wire logic [15:0] set_pow_o, // Power set
    input wire logic [15:0] slave_volt_o, // Slave U
    input wire logic [15:0] slave_curr_o, // Slave I
    input wire logic [15:0] slave_pow_o, // Slave P
    input wire logic running_o, // Running
    input wire logic alarm_o, // Alarm flag
    input wire logic error_o // Error flag
);
    import lws_pkg::*;
    wire any_alm = dev_alarm_i | overpower_protection_i | overcurrent_protection_i | event_alarm_i;
    wire cmd_wr = wr_i && addr_i == REG_CMD && !res_mode_i;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    alarm_halt_a:
    assert property (any_alm |=> !running_o && !input_on_o && alarm_o)
        else $error("alarm did not halt the run");
    start_run_a:
    assert property (cmd_wr && wdata_i == 32'h2 && input_on_o && !running_o && !any_alm
        && !alarm_o && !error_o |=> running_o && input_on_o) else $error("start ignored");
    stop_keep_a:
    assert property (cmd_wr && wdata_i == 32'h4 && running_o && !any_alm
        |=> !running_o && input_on_o) else $error("stop wrong");
    off_halt_a:
    assert property (cmd_wr && wdata_i == 32'h8 |=> !running_o && !input_on_o)
        else $error("input off wrong");
    res_block_a:
    assert property (res_mode_i && wr_i && !any_alm |=> $stable(running_o) && $stable(input_on_o))
        else $error("write taken in resistance mode");
    cfg_lock_a:
    assert property (wr_i && addr_i == REG_ULIM && input_on_o && $stable(gen_mode_i)
        |=> $stable(slave_volt_o)) else $error("limit changed with input on");
    pow_clamp_a:
    assert property (running_o && $stable(meas_volt_i)
        |-> 32'(set_curr_o) * 32'(meas_volt_i) <= {8'h00, set_pow_o, 8'h00})
        else $error("power above limit");
    gen_entry_a:
    assert property ($rose(gen_mode_i) |-> ##[1:2] slave_volt_o == NOMINAL
        && slave_curr_o == 16'h0000 && slave_pow_o == 16'h0000) else $error("limits not reset");
endmodule : lws_top_sva
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking testbench for the waveform sequencer core
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lws_pkg::*;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic gen_mode_i = 1'b0;
    logic res_mode_i = 1'b0;
    logic [3:0] alm = 4'h0;
    logic [15:0] meas_volt_i;
    logic [31:0] rdata_o;
    logic input_on_o, running_o, alarm_o, error_o;
    logic [15:0] set_volt_o, set_curr_o, set_pow_o, slave_volt_o, slave_curr_o, slave_pow_o;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [15:0] v [1200];
    logic [15:0] mx;
    int bad;
    int nrun;
    // Bad settings: ctrl, amplitude, offset, frequency, rise, fall
    logic [31:0] bc [6][6] = '{
        '{32'h0, 32'h2000, 32'h1000, 32'h3e8, 32'h1, 32'h1},
        '{32'h0, 32'h100, 32'h100, 32'h2711, 32'h1, 32'h1},
        '{32'h0, 32'h9000, 32'h9000, 32'h3e8, 32'h1, 32'h1},
        '{32'h1, 32'h9000, 32'h8000, 32'h3e8, 32'h1, 32'h1},
        '{32'h1, 32'h100, 32'h100, 32'h3e8, 32'h0, 32'h1},
        '{32'h1, 32'h1, 32'h0, 32'h3e8, 32'hd693a400, 32'hd693a400}};
    always #12.5 clock_i = ~clock_i;
    lws_top #(.NOMINAL(16'hffff)) dut (
        .clock_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .gen_mode_i,
        .res_mode_i, .dev_alarm_i(alm[0]), .overpower_protection_i(alm[1]),
        .overcurrent_protection_i(alm[2]), .event_alarm_i(alm[3]), .meas_volt_i,
        .input_on_o, .set_volt_o, .set_curr_o, .set_pow_o, .slave_volt_o, .slave_curr_o,
        .slave_pow_o, .running_o, .alarm_o, .error_o);
    lws_source_model src (.volt_o(meas_volt_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd
    task automatic cfg(input logic [31:0] c, a, o, f, r, fl);
        wr(REG_CTRL, c);
        wr(REG_AMPL, a);
        wr(REG_OFFS, o);
        wr(REG_FREQ, f);
        wr(REG_RISE, r);
        wr(REG_FALL, fl);
    endtask : cfg
    task automatic final_report;
        $display("Mismatches %0d of %0d checks", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (100000) @(posedge clock_i);
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i) gen_mode_i <= 1'b1;
        tick(3);
        chk(slave_volt_o, 32'hffff);
        chk({slave_curr_o, slave_pow_o}, 32'h0);
        wr(REG_ULIM, 32'h8000);
        wr(REG_ILIM, 32'h3800);
        wr(REG_PLIM, 32'h3000);
        chk(32'(slave_volt_o), 32'h00008000);
        chk({slave_curr_o, slave_pow_o}, 32'h38003000);
        rd(REG_ULIM, 32'h8000);
        rd(4'hf, 32'h0);
        for (int i = 0; i < 6; i++) begin
            cfg(bc[i][0], bc[i][1], bc[i][2], bc[i][3], bc[i][4], bc[i][5]);
            wr(REG_CMD, 32'h1);
            chk(input_on_o, 1'b0);
            chk(error_o, 1'b1);
            wr(REG_CMD, 32'h10);
        end
        // Current sine at the top frequency, peak above the power limit
        cfg(32'h2, 32'h2000, 32'h2000, 32'h2710, 32'h1, 32'h1);
        wr(REG_CMD, 32'h1);
        chk({input_on_o, running_o, set_curr_o}, 18'h20000);
        rd(REG_STAT, 32'h9);
        wr(REG_ULIM, 32'h100);
        rd(REG_ULIM, 32'h8000);
        @(posedge clock_i) res_mode_i <= 1'b1;
        wr(REG_CMD, 32'h2);
        chk(running_o, 1'b0);
        rd(REG_STAT, 32'hd);
        @(posedge clock_i) res_mode_i <= 1'b0;
        wr(REG_CMD, 32'h2);
        chk(running_o, 1'b1);
        mx = 16'h0;
        bad = 0;
        nrun = 0;
        for (int k = 0; k < 4000; k++) begin
            tick(1);
            if (set_curr_o > mx) mx = set_curr_o;
            if (set_volt_o !== 16'h8000 || set_pow_o !== 16'h3000) bad++;
            if (running_o !== 1'b1) nrun++;
        end
        chk(mx, 32'h3000);
        chk(bad, 0);
        chk(nrun, 0);
        wr(REG_CMD, 32'h4);
        chk({input_on_o, running_o, set_curr_o}, 18'h20000);
        wr(REG_CMD, 32'h8);
        chk({input_on_o, running_o}, 2'b00);
        wr(REG_CMD, 32'h2);
        chk({input_on_o, running_o}, 2'b11);
        wr(REG_CMD, 32'h8);
        for (int i = 0; i < 4; i++) begin
            wr(REG_CMD, 32'h1);
            wr(REG_CMD, 32'h2);
            @(posedge clock_i) alm <= 4'h1 << i;
            @(posedge clock_i) alm <= 4'h0;
            #1;
            chk({input_on_o, running_o, alarm_o}, 3'b001);
            wr(REG_CMD, 32'h10);
            chk(alarm_o, 1'b0);
        end
        // Voltage triangle: shortest rise, twice that fall
        wr(REG_PLIM, 32'hffff);
        wr(REG_CMD, 32'h2);
        chk({input_on_o, running_o}, 2'b00);
        cfg(32'h1, 32'h1000, 32'h2000, 32'h3e8, 32'h1, 32'h2);
        wr(REG_CMD, 32'h1);
        wr(REG_CMD, 32'h2);
        mx = 16'h0;
        bad = 0;
        nrun = 0;
        for (int k = 0; k < 2400; k++) begin
            tick(1);
            if (k < 1200) v[k] = set_volt_o;
            else if (v[k-1200] !== set_volt_o) bad++;
            if (set_volt_o > mx) mx = set_volt_o;
            if (set_curr_o !== 16'h3800) nrun++;
        end
        chk(bad, 0);
        chk(mx >= 16'h2ff0 && mx <= 16'h3000, 1'b1);
        chk(nrun, 0);
        final_report();
    end
endmodule : tb
bind lws_top lws_top_sva #(.VAL_WIDTH(VAL_WIDTH), .NOMINAL(NOMINAL)) u_sva (
    .clock_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .gen_mode_i, .res_mode_i, .dev_alarm_i,
    .overpower_protection_i, .overcurrent_protection_i, .event_alarm_i, .meas_volt_i,
    .input_on_o, .set_curr_o, .set_pow_o, .slave_volt_o, .slave_curr_o, .slave_pow_o,
    .running_o, .alarm_o, .error_o);
`default_nettype wire
